// ### pdt_pkg.sv
package pdt_pkg;
	// ----------------------------------------
	// register select indices (5-bit selects)
	// ----------------------------------------
	localparam logic [4:0] PDT_ADDR_CONTROL   = 5'h10;
	localparam logic [4:0] PDT_ADDR_VECTOR    = 5'h11;
	localparam logic [4:0] PDT_ADDR_PRE_NULL  = 5'h12;
	localparam logic [4:0] PDT_ADDR_PRE_HIGH  = 5'h13;
	localparam logic [4:0] PDT_ADDR_PRE_MID   = 5'h14;
	localparam logic [4:0] PDT_ADDR_PRE_LOW   = 5'h15;
	localparam logic [4:0] PDT_ADDR_CNT_NULL  = 5'h16;
	localparam logic [4:0] PDT_ADDR_CNT_HIGH  = 5'h17;
	localparam logic [4:0] PDT_ADDR_CNT_MID   = 5'h18;
	localparam logic [4:0] PDT_ADDR_CNT_LOW   = 5'h19;
	localparam logic [4:0] PDT_ADDR_STATUS    = 5'h1a;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] PDT_VECTOR_RST     = 8'h0f;
	localparam logic [7:0] PDT_CONTROL_RST    = 8'h00;
	localparam logic [7:0] PDT_CONTROL_MASK   = 8'hf7;
	localparam int         PDT_BIT_ENABLE     = 0;
	localparam int         PDT_BIT_CLK_LO     = 1;
	localparam int         PDT_BIT_CLK_HI     = 2;
	localparam int         PDT_BIT_ZD_CTRL    = 4;
	localparam int         PDT_BIT_PIN_LO     = 5;
	localparam int         PDT_BIT_PIN_HI     = 7;
	localparam int         PDT_BIT_ZDS        = 0;
	localparam logic [4:0] PDT_PRESCALE_TOP   = 5'h1f;
	localparam int         PDT_SYNC_STAGES    = 3;

	// ----------------------------------------
	// clock source selections
	// ----------------------------------------
	typedef enum logic [1:0] {
		PDT_SRC_SYS       = 2'h0,
		PDT_SRC_SYS_GATED = 2'h1,
		PDT_SRC_IN_PRE    = 2'h2,
		PDT_SRC_IN_DIRECT = 2'h3
	} pdt_src_t;

	// ----------------------------------------
	// acknowledge handshake states
	// ----------------------------------------
	typedef enum logic [2:0] {
		PDT_ACK_IDLE  = 3'b001,
		PDT_ACK_DRIVE = 3'b010,
		PDT_ACK_DONE  = 3'b100
	} pdt_ack_state_t;
endpackage

// ### pdt_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_sync
	import pdt_pkg::*;
#(
	parameter int STAGES = PDT_SYNC_STAGES
) (
	input  wire logic mclk_in,
	input  wire logic arst_n_in,
	input  wire logic ce_in,
	input  wire logic async_in,
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);
	logic [STAGES-1:0] shift;
	logic [STAGES-1:0] next_shift;
	logic              agreed;
	logic              next_agreed;

	// ----------------------------------------
	// shift chain, later stages vote
	// ----------------------------------------
	always_comb begin
		next_shift  = {shift[STAGES-2:0], async_in};
		next_agreed = agreed;
		if (shift[STAGES-1] == shift[STAGES-2]) begin
			next_agreed = shift[STAGES-2]; // change counts when stages agree
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shift  <= '0;
			agreed <= 1'b0;
		end else if (ce_in) begin
			shift  <= next_shift;
			agreed <= next_agreed;
		end
	end

	// edges of the agreed level
	assign level_out = agreed;
	assign rise_out  = ce_in & next_agreed & ~agreed;
	assign fall_out  = ce_in & ~next_agreed & agreed;
endmodule // pdt_sync
`default_nettype wire

// ### pdt_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - 8-bit vector register, same value on normal read and on acknowledge
// - reset loads the vector register with 0f
// - preload value is three byte registers high, mid, low
// - address below high preload or high count byte reads zero, ignores writes
// - preload readable and writable any time, independent of counter load
// - reset leaves the preload registers untouched
// - count addresses show the live counter, not latched
// - writes to count addresses are acknowledged and discarded
// - zero-detect flag sets when counter steps from one to zero
// - flag clears on direct clear or while halted; reset halts
// - status read has no effect; writing bit 0 as one clears flag
// - clearing wins over setting in the same cycle
// - status bits 7 to 1 read as zero
// - interrupt mode asserts request on zero, reloads on next counter clock
// - square wave toggles on zero, high before first enable
// - output pin is a port pin after reset until timer selected
// - zero-detect control one makes counter roll over instead of reload
// - watchdog: timer input gates run, output flags overlong high input
// - control fields: pin function, roll-over, clock source, enable; reset clears
// - clock sources via 5-bit prescaler or direct input; step on 00 to 1f
// - gated input low clears flag, negates request, stops, prescaler all ones
module pdt_timer
	import pdt_pkg::*;
#(
	parameter int CNT_W = 24
) (
	input  wire logic       mclk_in,
	input  wire logic       arst_n_in,
	input  wire logic       ce_in,
	input  wire logic       sel_n_in,
	input  wire logic       rd_wr_n_in,
	input  wire logic [4:0] reg_sel_in,
	input  wire logic [7:0] wdata_in,
	output logic      [7:0] rdata_out,
	output logic            rdata_oe_out,
	output logic            ack_n_out,
	input  wire logic       timer_input_in,
	input  wire logic       timer_irq_ack_n_in,
	input  wire logic       port_pin_3_in,
	input  wire logic       port_pin_3_data_in,
	input  wire logic       port_pin_3_dir_in,
	output logic            port_pin_3_out,
	output logic            port_pin_3_oe_out,
	output logic            timer_irq_ack_pin_out,
	output logic            zero_detect_flag_out,
	output logic            running_out
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	// programmable registers
	logic [7:0]       timer_vector, next_timer_vector;
	logic [7:0]       timer_control, next_timer_control;
	logic [7:0]       preload_high, next_preload_high;
	logic [7:0]       preload_mid, next_preload_mid;
	logic [7:0]       preload_low, next_preload_low;

	// timer datapath
	logic [CNT_W-1:0] counter, next_counter;
	logic [4:0]       prescale, next_prescale;
	logic             zero_detect_flag, next_zero_detect_flag;
	logic             reload_pend, next_reload_pend;
	logic             wave, next_wave;

	// bus answer
	logic [7:0]       rdata, next_rdata;
	logic             bus_done, next_bus_done;
	pdt_ack_state_t   ack_state, next_ack_state;

	// ----------------------------------------
	// internal signals
	// ----------------------------------------
	logic             tin_level, tin_rise, tin_fall;
	logic             sel_sync, sel_rise, sel_fall;
	logic             iack_level, iack_rise, iack_fall;
	logic             bus_wr, bus_rd, status_wr;
	logic             run, count_tick, pre_tick, zero_hit, clr_flag;
	logic [23:0]      preload_value;
	pdt_src_t         src;
	logic [2:0]       pin_mode;

	// ----------------------------------------
	// synchronisers for pin inputs
	// ----------------------------------------
	// external timer input, level and edges
	pdt_sync u_sync_tin (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.ce_in     (ce_in),
		.async_in  (timer_input_in),
		.level_out (tin_level),
		.rise_out  (tin_rise),
		.fall_out  (tin_fall)
	);

	// chip select, taken on its synchronised assertion
	pdt_sync u_sync_sel (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.ce_in     (ce_in),
		.async_in  (~sel_n_in),
		.level_out (sel_sync),
		.rise_out  (sel_rise),
		.fall_out  (sel_fall)
	);

	// interrupt acknowledge input
	pdt_sync u_sync_iack (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.ce_in     (ce_in),
		.async_in  (~timer_irq_ack_n_in),
		.level_out (iack_level),
		.rise_out  (iack_rise),
		.fall_out  (iack_fall)
	);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// read mux, unmapped and null selects read zero
	function automatic logic [7:0] pdt_read(input logic [4:0] a);
		unique case (a)
			PDT_ADDR_CONTROL:  pdt_read = timer_control;
			PDT_ADDR_VECTOR:   pdt_read = timer_vector;
			PDT_ADDR_PRE_HIGH: pdt_read = preload_high;
			PDT_ADDR_PRE_MID:  pdt_read = preload_mid;
			PDT_ADDR_PRE_LOW:  pdt_read = preload_low;
			PDT_ADDR_CNT_HIGH: pdt_read = counter[23:16];
			PDT_ADDR_CNT_MID:  pdt_read = counter[15:8];
			PDT_ADDR_CNT_LOW:  pdt_read = counter[7:0];
			PDT_ADDR_STATUS:   pdt_read = {7'h00, zero_detect_flag};
			default:           pdt_read = 8'h00;
		endcase
	endfunction

	// control fields
	assign src           = pdt_src_t'(timer_control[PDT_BIT_CLK_HI:PDT_BIT_CLK_LO]);
	assign pin_mode      = timer_control[PDT_BIT_PIN_HI:PDT_BIT_PIN_LO];
	assign preload_value = {preload_high, preload_mid, preload_low};
	assign bus_rd        = sel_rise & rd_wr_n_in;
	assign bus_wr        = sel_rise & ~rd_wr_n_in;
	assign status_wr     = bus_wr & (reg_sel_in == PDT_ADDR_STATUS);

	// ----------------------------------------
	// run state and counter clocking
	// ----------------------------------------
	// run gating, prescaler tick and counter step
	always_comb begin
		run      = timer_control[PDT_BIT_ENABLE];
		pre_tick = 1'b0;
		if (src == PDT_SRC_SYS_GATED) begin
			run = run & tin_level;
		end

		// prescaler input by clock source
		unique case (src)
			PDT_SRC_SYS, PDT_SRC_SYS_GATED: pre_tick = ce_in;
			PDT_SRC_IN_PRE:                 pre_tick = tin_rise;
			PDT_SRC_IN_DIRECT:              pre_tick = 1'b0;
		endcase

		count_tick = run & ((src == PDT_SRC_IN_DIRECT) ? tin_rise : (pre_tick & (prescale == 5'h00)));
		zero_hit   = count_tick & ~reload_pend & (counter == 24'h000001);
		clr_flag   = ~run | (status_wr & wdata_in[PDT_BIT_ZDS]);
	end

	// ----------------------------------------
	// register writes and timer datapath
	// ----------------------------------------
	// next values for registers, counter and flag
	always_comb begin
		next_timer_vector     = timer_vector;
		next_timer_control    = timer_control;
		next_preload_high     = preload_high;
		next_preload_mid      = preload_mid;
		next_preload_low      = preload_low;
		next_counter          = counter;
		next_prescale         = prescale;
		next_reload_pend      = reload_pend;
		next_wave             = wave;
		next_zero_detect_flag = zero_detect_flag;
		if (bus_wr) begin
			unique case (reg_sel_in)
				PDT_ADDR_CONTROL:  next_timer_control = wdata_in & PDT_CONTROL_MASK;
				PDT_ADDR_VECTOR:   next_timer_vector  = wdata_in;
				PDT_ADDR_PRE_HIGH: next_preload_high  = wdata_in;
				PDT_ADDR_PRE_MID:  next_preload_mid   = wdata_in;
				PDT_ADDR_PRE_LOW:  next_preload_low   = wdata_in;
				default:           ;
			endcase
		end

		// halted: prescaler all ones, next run starts from preload
		if (!run) begin
			next_prescale    = PDT_PRESCALE_TOP;
			next_reload_pend = 1'b1; // start from preload
			if (!timer_control[PDT_BIT_ENABLE]) begin
				next_wave = 1'b1;
			end
		end else begin
			if (pre_tick) begin
				next_prescale = prescale - 5'h01; // wraps 00 to 1f
			end
			if (count_tick) begin
				if (reload_pend) begin
					next_counter     = preload_value;
					next_reload_pend = 1'b0;
				end else begin
					next_counter = counter - 24'h000001;
					if (zero_hit) begin
						next_wave        = ~wave;
						next_reload_pend = ~timer_control[PDT_BIT_ZD_CTRL];
					end
				end
			end
		end

		// clear dominant flag
		if (clr_flag) begin
			next_zero_detect_flag = 1'b0;
		end else if (zero_hit) begin
			next_zero_detect_flag = 1'b1;
		end
	end

	// ----------------------------------------
	// timer and register state
	// ----------------------------------------
	// reset halts the timer and reloads the vector
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			timer_vector     <= PDT_VECTOR_RST;
			timer_control    <= PDT_CONTROL_RST;
			counter          <= '0;
			prescale         <= PDT_PRESCALE_TOP;
			reload_pend      <= 1'b1;
			wave             <= 1'b1;
			zero_detect_flag <= 1'b0;
		end else if (ce_in) begin
			timer_vector     <= next_timer_vector;
			timer_control    <= next_timer_control;
			counter          <= next_counter;
			prescale         <= next_prescale;
			reload_pend      <= next_reload_pend;
			wave             <= next_wave;
			zero_detect_flag <= next_zero_detect_flag;
		end
	end

	// preload bytes carry no reset
	always_ff @(posedge mclk_in) begin
		if (ce_in) begin
			preload_high <= next_preload_high;
			preload_mid  <= next_preload_mid;
			preload_low  <= next_preload_low;
		end
	end

	// ----------------------------------------
	// bus answer and acknowledge cycle
	// ----------------------------------------
	// read data capture and acknowledge sequence
	always_comb begin
		next_rdata     = rdata;
		next_bus_done  = bus_done;
		next_ack_state = ack_state;
		if (bus_rd) begin
			next_rdata = pdt_read(reg_sel_in);
		end

		// acknowledge stands while the synchronised select is asserted
		if (sel_rise) begin
			next_bus_done = 1'b1;
		end else if (sel_fall) begin
			next_bus_done = 1'b0;
		end

		// vector is driven one clock before the acknowledge
		unique case (ack_state)
			PDT_ACK_IDLE: begin
				if (iack_rise && pin_mode == 3'b101 && zero_detect_flag) begin
					next_ack_state = PDT_ACK_DRIVE;
					next_rdata     = timer_vector;
				end
			end
			PDT_ACK_DRIVE: begin
				next_ack_state = iack_level ? PDT_ACK_DONE : PDT_ACK_IDLE;
			end
			PDT_ACK_DONE: begin
				if (iack_fall || !iack_level) begin
					next_ack_state = PDT_ACK_IDLE;
				end
			end
		endcase
	end

	// bus state registers
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata     <= 8'h00;
			bus_done  <= 1'b0;
			ack_state <= PDT_ACK_IDLE;
		end else if (ce_in) begin
			rdata     <= next_rdata;
			bus_done  <= next_bus_done;
			ack_state <= next_ack_state;
		end
	end

	// data drive and acknowledge levels
	assign rdata_out    = rdata;
	assign rdata_oe_out = (bus_done & sel_sync & rd_wr_n_in) | (ack_state != PDT_ACK_IDLE);
	assign ack_n_out    = ~((bus_done & sel_sync) | (ack_state == PDT_ACK_DONE));

	// ----------------------------------------
	// output pin function
	// ----------------------------------------
	// pin 3 carries port data, square wave or request
	always_comb begin
		port_pin_3_out    = port_pin_3_data_in;
		port_pin_3_oe_out = port_pin_3_dir_in;
		if (pin_mode[2:1] == 2'b01) begin
			port_pin_3_out    = wave;
			port_pin_3_oe_out = 1'b1;
		end else if (pin_mode[2]) begin
			port_pin_3_out    = 1'b0;
			port_pin_3_oe_out = pin_mode[0] & zero_detect_flag;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	// function indications for the surrounding port logic
	assign timer_irq_ack_pin_out = (pin_mode[2:1] == 2'b10);
	assign zero_detect_flag_out  = zero_detect_flag;
	assign running_out           = run;
endmodule // pdt_timer
`default_nettype wire

// ### pdt_timer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_timer_chk
	import pdt_pkg::*;
(
	input wire logic       mclk_in,
	input wire logic       arst_n_in,
	input wire logic       ce_in,
	input wire logic       sel_n_in,
	input wire logic       rd_wr_n_in,
	input wire logic [4:0] reg_sel_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] rdata_out,
	input wire logic       rdata_oe_out,
	input wire logic       ack_n_out,
	input wire logic       timer_input_in,
	input wire logic       timer_irq_ack_n_in,
	input wire logic       port_pin_3_in,
	input wire logic       port_pin_3_data_in,
	input wire logic       port_pin_3_dir_in,
	input wire logic       port_pin_3_out,
	input wire logic       port_pin_3_oe_out,
	input wire logic       timer_irq_ack_pin_out,
	input wire logic       zero_detect_flag_out,
	input wire logic       running_out
);
	// ----------------------------------------
	// handshake and register checks
	// ----------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);
	logic ack_n_prev;
	logic rd_take;

	// acknowledge level one clock back, marks the taking edge of a read
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_n_prev <= 1'b1;
		end else begin
			ack_n_prev <= ack_n_out;
		end
	end
	assign rd_take = ack_n_prev && !ack_n_out && !sel_n_in && rd_wr_n_in;
	a_ack_cause: assert property ($fell(ack_n_out) |-> !$past(sel_n_in, 3) || !$past(timer_irq_ack_n_in, 3))
		else $error("acknowledge without a request");
	a_ack_release: assert property ($rose(sel_n_in) && timer_irq_ack_n_in |-> ##[1:8] ack_n_out)
		else $error("acknowledge not released");
	a_sel_synced: assert property ($fell(sel_n_in) |-> ack_n_out [*3])
		else $error("acknowledge before select synchronised");
	a_read_drive: assert property (rd_take |-> rdata_oe_out)
		else $error("read data not driven");
	a_null_zero: assert property (rd_take && (reg_sel_in == PDT_ADDR_PRE_NULL || reg_sel_in == PDT_ADDR_CNT_NULL)
		|-> rdata_out == 8'h00)
		else $error("null location not zero");
	a_status_pad: assert property (rd_take && reg_sel_in == PDT_ADDR_STATUS |-> rdata_out[7:1] == 7'h00)
		else $error("status upper bits not zero");
	a_w1c_clear: assert property ($fell(ack_n_out) && !sel_n_in && !rd_wr_n_in && reg_sel_in == PDT_ADDR_STATUS
		&& wdata_in[0] |-> !zero_detect_flag_out)
		else $error("flag not cleared by write");
	a_halt_clear: assert property (!running_out && !$past(running_out) && !$past(running_out, 2)
		|-> !zero_detect_flag_out)
		else $error("flag set while halted");
	a_set_running: assert property ($rose(zero_detect_flag_out) |-> $past(running_out))
		else $error("flag set without running");
	a_irq_pin: assert property (timer_irq_ack_pin_out && port_pin_3_oe_out
		|-> (!port_pin_3_out && zero_detect_flag_out))
		else $error("request pin driven without flag");
endmodule // pdt_timer_chk
bind pdt_timer pdt_timer_chk i_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .sel_n_in(sel_n_in),
	.rd_wr_n_in(rd_wr_n_in), .reg_sel_in(reg_sel_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
	.rdata_oe_out(rdata_oe_out), .ack_n_out(ack_n_out), .timer_input_in(timer_input_in),
	.timer_irq_ack_n_in(timer_irq_ack_n_in), .port_pin_3_in(port_pin_3_in), .port_pin_3_data_in(port_pin_3_data_in),
	.port_pin_3_dir_in(port_pin_3_dir_in), .port_pin_3_out(port_pin_3_out), .port_pin_3_oe_out(port_pin_3_oe_out),
	.timer_irq_ack_pin_out(timer_irq_ack_pin_out), .zero_detect_flag_out(zero_detect_flag_out),
	.running_out(running_out));
`default_nettype wire

// ### pdt_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pdt_host_model (
	input  wire logic       mclk_in,
	input  wire logic       ack_n_in,
	input  wire logic [7:0] rdata_in,
	output logic            sel_n_out,
	output logic            rd_wr_n_out,
	output logic      [4:0] reg_sel_out,
	output logic      [7:0] wdata_out,
	output logic            iack_n_out
);
	// ----------------------------------------
	// bus cycle: hold request until acknowledge
	// ----------------------------------------
	initial begin
		sel_n_out = 1'b1;
		iack_n_out = 1'b1;
		rd_wr_n_out = 1'b1;
		reg_sel_out = 5'h00;
		wdata_out = 8'h00;
	end
	task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic ia,
		output logic [7:0] q, output logic ok);
		int n;
		@(posedge mclk_in);
		rd_wr_n_out <= rw;
		reg_sel_out <= a;
		wdata_out <= d;
		if (ia) iack_n_out <= 1'b0;
		else sel_n_out <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk_in);
			if (ack_n_in === 1'b0) break;
		end
		q = rdata_in;
		ok = n < 40;
		sel_n_out <= 1'b1;
		iack_n_out <= 1'b1;
		wdata_out <= ~d; // released bus stops showing the old data
		for (n = 0; n < 40 && ack_n_in !== 1'b1; n++) @(posedge mclk_in);
		ok = ok && n < 40;
	endtask
endmodule // pdt_host_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pdt_pkg::*;
	logic       mclk_in, arst_n_in, sel_n, rd_wr_n, iack_n, timer_input, p3d, p3dir, oe, ack_n, p3o, p3oe, tiap, zdf, run, ok;
	logic       ce;
	logic [4:0] rsel;
	logic [7:0] wd, rdata, q, lf;
	int         fail_count, check_count;
	int         mdl [int];
	// ----------------------------------------
	// clock, design and bus partner
	// ----------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	pdt_timer i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .ce_in(ce), .sel_n_in(sel_n),
		.rd_wr_n_in(rd_wr_n), .reg_sel_in(rsel), .wdata_in(wd), .rdata_out(rdata), .rdata_oe_out(oe),
		.ack_n_out(ack_n), .timer_input_in(timer_input), .timer_irq_ack_n_in(iack_n), .port_pin_3_in(1'b0),
		.port_pin_3_data_in(p3d), .port_pin_3_dir_in(p3dir), .port_pin_3_out(p3o), .port_pin_3_oe_out(p3oe),
		.timer_irq_ack_pin_out(tiap), .zero_detect_flag_out(zdf), .running_out(run));
	pdt_host_model i_host (.mclk_in(mclk_in), .ack_n_in(ack_n), .rdata_in(rdata), .sel_n_out(sel_n),
		.rd_wr_n_out(rd_wr_n), .reg_sel_out(rsel), .wdata_out(wd), .iack_n_out(iack_n));
	// ----------------------------------------
	// helpers: compare, register model, waits
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic ia);
		i_host.xfer(rw, a, d, ia, q, ok);
		if (ok !== 1'b1) begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		acc(1'b0, a, d, 1'b0);
		if (a == PDT_ADDR_CONTROL) mdl[a] = d & PDT_CONTROL_MASK;
		else if (a >= PDT_ADDR_VECTOR && a <= PDT_ADDR_PRE_LOW && a != PDT_ADDR_PRE_NULL) mdl[a] = d;
	endtask
	task automatic rdx(input logic [4:0] a, input logic [7:0] exp);
		acc(1'b1, a, 8'h00, 1'b0);
		chk("register", q, exp);
	endtask
	task automatic rd(input logic [4:0] a);
		rdx(a, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
	endtask
	task automatic rst();
		@(posedge mclk_in);
		arst_n_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		mdl[PDT_ADDR_VECTOR] = 8'h0f;
		mdl[PDT_ADDR_CONTROL] = 8'h00;
	endtask
	task automatic wflag();
		int n;
		for (n = 0; n < 600 && zdf !== 1'b1; n++) @(posedge mclk_in);
		if (n == 600) begin
			fail_count++;
			summarize();
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		arst_n_in = 1'b0;
		timer_input = 1'b0;
		ce = 1'b1;
		p3d = 1'b0;
		p3dir = 1'b1;
		lf = 8'h13;
		rst();
		@(posedge mclk_in);
		p3d <= 1'b1;
		repeat (2) @(posedge mclk_in);
		chk("pin3", 8'(p3o), 8'h01);
		rd(PDT_ADDR_VECTOR);
		rd(PDT_ADDR_CONTROL);
		rdx(PDT_ADDR_STATUS, 8'h00);
		for (int a = PDT_ADDR_VECTOR; a <= PDT_ADDR_CNT_NULL; a++) begin
			lf = lfsr(lf);
			wr(5'(a), lf);
		end
		for (int a = PDT_ADDR_VECTOR; a <= PDT_ADDR_CNT_NULL; a++) rd(5'(a));
		wr(PDT_ADDR_PRE_HIGH, 8'h00);
		wr(PDT_ADDR_PRE_MID, 8'h00);
		wr(PDT_ADDR_PRE_LOW, 8'h02);
		wr(PDT_ADDR_CONTROL, 8'ha1);
		wflag();
		repeat (3) @(posedge mclk_in);
		chk("irq", 8'({tiap, p3o, p3oe}), 8'h05);
		rdx(PDT_ADDR_STATUS, 8'h01);
		rdx(PDT_ADDR_STATUS, 8'h01);
		acc(1'b1, 5'h00, 8'h00, 1'b1);
		chk("iack", q, 8'(mdl[PDT_ADDR_VECTOR]));
		wr(PDT_ADDR_STATUS, 8'h01);
		rdx(PDT_ADDR_STATUS, 8'h00);
		wr(PDT_ADDR_CONTROL, 8'hb1);
		wflag();
		repeat (40) @(posedge mclk_in);
		rdx(PDT_ADDR_CNT_HIGH, 8'hff);
		wr(PDT_ADDR_CONTROL, 8'h00);
		wr(PDT_ADDR_CNT_HIGH, 8'h00);
		rdx(PDT_ADDR_CNT_HIGH, 8'hff);
		chk("halt", 8'({run, zdf}), 8'h00);
		wr(PDT_ADDR_CONTROL, 8'h40);
		chk("square", 8'(p3o), 8'h01);
		wr(PDT_ADDR_CONTROL, 8'h41);
		wflag();
		repeat (3) @(posedge mclk_in);
		chk("square", 8'(p3o), 8'h00);
		ce <= 1'b0;
		repeat (120) @(posedge mclk_in);
		chk("freeze", 8'({p3o, zdf}), 8'h01);
		ce <= 1'b1;
		wr(PDT_ADDR_CONTROL, 8'hb3);
		repeat (8) @(posedge mclk_in);
		chk("gated", 8'(run), 8'h00);
		timer_input <= 1'b1;
		repeat (8) @(posedge mclk_in);
		chk("gated", 8'(run), 8'h01);
		wflag();
		chk("watchdog", 8'({p3o, p3oe}), 8'h01);
		timer_input <= 1'b0;
		repeat (8) @(posedge mclk_in);
		chk("gated", 8'({run, zdf, p3oe}), 8'h00);
		wr(PDT_ADDR_CONTROL, 8'ha1);
		rst();
		@(posedge mclk_in);
		chk("reset", 8'(run), 8'h00);
		rd(PDT_ADDR_VECTOR);
		rd(PDT_ADDR_CONTROL);
		for (int a = PDT_ADDR_PRE_HIGH; a <= PDT_ADDR_PRE_LOW; a++) rd(5'(a));
		summarize();
	end
endmodule // tb
`default_nettype wire
